// ===== rtl/scp_pkg.sv
// constants and carrier types for the dual-role spi port.
// assumes a single 100 MHz clock and configuration held steady per word.
// Summary of operation
// - Mode bit set makes the port controller, driving serial clock and select.
// - Mode bit clear makes it peripheral: clock and data in, reply out.
// - Phase bit chooses which edges sample the data, and for the peripheral which launch.
// - Polarity bit chooses which clock level is idle, setting edge sense.
// - Prescale 1..255 gives value+1 bus cycles per clock; 0 gives two.
// - Lead wait and lag wait each come from their own delay field.
// - Phase 1, polarity 0: half period plus lead+2 cycles to first edge.
// - Phase 1, polarity 1: half period plus lead+2 cycles, or lead+3 with select hold on.
// - Phase 1: select stays asserted lag+1 cycles after the last edge.
// - Phase 1 controller samples on falling (pol 0) or rising (pol 1).
// - Phase 1 controller changes data after falling (pol 0) or rising.
// - Peripheral updates reply after rising if pol equals phase, else falling.
// - Peripheral samples on falling if pol equals phase, else rising.
package scp_pkg;
	localparam int WORD_BITS_DEF = 16;
	localparam int PS_BITS       = 8;
	localparam int DLY_BITS      = 8;
	localparam int TMR_BITS      = 10;

	localparam logic [TMR_BITS-1:0] LEAD_EXTRA      = 10'h002;
	localparam logic [TMR_BITS-1:0] LEAD_EXTRA_HOLD = 10'h003;
	localparam logic [TMR_BITS-1:0] LAG_EXTRA       = 10'h001;
	localparam logic [TMR_BITS-1:0] PS_ZERO_PERIOD  = 10'h002;

	localparam int CLK_PERIOD_PS   = 10000;
	localparam int MIN_SCLK_PS     = 25000;
	localparam int MIN_PERIOD_CYC  =
		(MIN_SCLK_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	localparam logic RST_SCLK = 1'h0;
	localparam logic RST_CS_N = 1'h1;
	localparam logic RST_DATA = 1'h0;

	typedef struct packed {
		logic               polarity;
		logic               phase;
		logic [PS_BITS-1:0] clk_prescale;
	} scp_format_s;

	typedef struct packed {
		logic [DLY_BITS-1:0] cs_lead_delay;
		logic [DLY_BITS-1:0] cs_lag_delay;
	} scp_delay_s;

	typedef enum logic [3:0] {
		C_IDLE  = 4'h1,
		C_LEAD  = 4'h2,
		C_SHIFT = 4'h4,
		C_LAG   = 4'h8
	} scp_cstate_e;
endpackage

// ===== rtl/scp_spi.sv
// dual-role spi port: controller engine, peripheral engine, pin steering.
// config ports come from same-clock logic; pins come from outside.
`timescale 1ns/1ps
module scp_spi
	import scp_pkg::*;
#(
	parameter int WORD_BITS = WORD_BITS_DEF
) (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 resetn,
	// configuration
	input  wire logic                 controller_sel,
	input  wire scp_format_s          format_reg,
	input  wire scp_delay_s           cs_delay_reg,
	input  wire logic                 cs_keep_asserted,
	// transmit word
	input  wire logic [WORD_BITS-1:0] tx_word,
	input  wire logic                 tx_valid,
	output logic                      tx_ready,
	// receive word
	output logic      [WORD_BITS-1:0] rx_word,
	output logic                      rx_valid,
	// status
	output logic                      busy,
	output logic                      sclk_rate_fault,
	// serial clock pin
	input  wire logic                 serial_clk_i,
	output logic                      serial_clk_o,
	output logic                      serial_clk_oe_n,
	// chip select pin
	input  wire logic                 cs_n_i,
	output logic                      cs_n_o,
	output logic                      cs_oe_n,
	// controller-out data pin
	input  wire logic                 ctrl_out_data_i,
	output logic                      ctrl_out_data_o,
	output logic                      ctrl_out_data_oe_n,
	// controller-in data pin
	input  wire logic                 ctrl_in_data_i,
	output logic                      ctrl_in_data_o,
	output logic                      ctrl_in_data_oe_n
);
	localparam int CNT_BITS = $clog2(2 * WORD_BITS + 1);
	localparam logic [CNT_BITS-1:0] LAST_EDGE = CNT_BITS'(2 * WORD_BITS - 1);
	localparam logic [CNT_BITS-1:0] LAST_BIT  = CNT_BITS'(WORD_BITS - 1);
	localparam logic [TMR_BITS-1:0] TMR_ONE   = 10'h001;

	function automatic logic [TMR_BITS-1:0] clk_period(
		input logic [PS_BITS-1:0] ps
	);
		if (ps == '0) begin
			clk_period = PS_ZERO_PERIOD;
		end else begin
			clk_period = TMR_BITS'(ps) + TMR_ONE;
		end
	endfunction

	// synchronised pins
	logic              sclk_s;
	logic              cs_n_s;
	logic              mosi_s;
	logic              miso_s;

	scp_sync #(.WIDTH(4), .RESET_VAL({RST_SCLK, RST_CS_N, RST_DATA,
		RST_DATA})) u_sync (
		.clk     (clk),
		.resetn  (resetn),
		.async_in({serial_clk_i, cs_n_i, ctrl_out_data_i, ctrl_in_data_i}),
		.stable  ({sclk_s, cs_n_s, mosi_s, miso_s})
	);

	// timing derived from the format and delay settings
	logic [TMR_BITS-1:0] period;
	logic [TMR_BITS-1:0] half_lo;
	logic [TMR_BITS-1:0] half_hi;
	logic [TMR_BITS-1:0] lead_cyc;
	logic [TMR_BITS-1:0] lag_cyc;
	logic                pol;
	logic                pha;

	always_comb begin
		pol      = format_reg.polarity;
		pha      = format_reg.phase;
		period   = clk_period(format_reg.clk_prescale);
		half_lo  = period >> 1;
		half_hi  = period - half_lo;
		lead_cyc = TMR_BITS'(cs_delay_reg.cs_lead_delay);
		// extra cycle only for phase 1, polarity 1 with hold on
		if (pha && pol && cs_keep_asserted) begin
			lead_cyc = lead_cyc + LEAD_EXTRA_HOLD;
		end else begin
			lead_cyc = lead_cyc + LEAD_EXTRA;
		end
		lag_cyc  = TMR_BITS'(cs_delay_reg.cs_lag_delay) + LAG_EXTRA;
	end

	// transmit holding register shared by both roles
	logic [WORD_BITS-1:0] hold_word;
	logic                 hold_full;
	logic                 next_full;
	logic                 c_take;
	logic                 p_take;

	scp_cstate_e          cst;
	logic [TMR_BITS-1:0]  tmr;
	logic [CNT_BITS-1:0]  edge_cnt;
	logic                 sclk;
	logic                 last_edge;
	logic                 b2b;
	logic                 p_cs_fall;
	logic                 cs_n_prev;

	always_comb begin
		last_edge = (cst == C_SHIFT) && (tmr == TMR_ONE)
			&& (edge_cnt == LAST_EDGE);
		b2b       = last_edge && cs_keep_asserted && hold_full;
		c_take    = controller_sel && hold_full
			&& ((cst == C_IDLE) || b2b);
		p_cs_fall = !controller_sel && cs_n_prev && !cs_n_s;
		p_take    = p_cs_fall && hold_full;
		next_full = hold_full;
		if (c_take || p_take) begin
			next_full = 1'b0;
		end
		if (tx_valid && tx_ready) begin
			next_full = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			hold_full <= 1'b0;
			tx_ready  <= 1'b0;
			hold_word <= '0;
		end else begin
			hold_full <= next_full;
			tx_ready  <= !next_full;
			if (tx_valid && tx_ready) begin
				hold_word <= tx_word;
			end
		end
	end

	// controller engine
	logic [WORD_BITS-1:0] c_tx;
	logic [WORD_BITS-1:0] c_rx;
	logic                 c_mosi;
	logic                 c_cs_n;
	logic                 c_done;
	logic [WORD_BITS-1:0] c_word;

	// sampling sees the pin four cycles late; slow prescales absorb it
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cst      <= C_IDLE;
			tmr      <= '0;
			edge_cnt <= '0;
			sclk     <= RST_SCLK;
			c_cs_n   <= RST_CS_N;
			c_mosi   <= RST_DATA;
			c_tx     <= '0;
			c_rx     <= '0;
			c_done   <= 1'b0;
			c_word   <= '0;
		end else begin
			c_done <= 1'b0;
			if (!controller_sel) begin
				cst    <= C_IDLE;
				c_cs_n <= RST_CS_N;
				sclk   <= pol;
			end else begin
				case (cst)
				C_IDLE: begin
					sclk <= pol;
					if (c_take) begin
						c_cs_n   <= 1'b0;
						c_tx     <= hold_word;
						c_mosi   <= hold_word[WORD_BITS-1];
						edge_cnt <= '0;
						tmr      <= lead_cyc + half_lo - TMR_ONE;
						cst      <= C_LEAD;
					end
				end
				C_LEAD: begin
					if (tmr == TMR_ONE) begin
						cst <= C_SHIFT;
					end else begin
						tmr <= tmr - TMR_ONE;
					end
				end
				C_SHIFT: begin
					if (tmr != TMR_ONE) begin
						tmr <= tmr - TMR_ONE;
					end else begin
						sclk     <= !sclk;
						edge_cnt <= edge_cnt + 1'b1;
						tmr      <= (sclk == pol) ? half_hi : half_lo;
						if (!edge_cnt[0]) begin
							// leading edge: phase 0 samples here
							if (!pha) begin
								c_rx <= {c_rx[WORD_BITS-2:0], miso_s};
							end
						end else begin
							// trailing edge: phase 1 samples, both launch
							if (pha) begin
								c_rx <= {c_rx[WORD_BITS-2:0], miso_s};
							end
							c_tx   <= {c_tx[WORD_BITS-2:0], 1'b0};
							c_mosi <= c_tx[WORD_BITS-2];
						end
						if (last_edge) begin
							c_done <= 1'b1;
							c_word <= pha ? {c_rx[WORD_BITS-2:0], miso_s}
								: c_rx;
							if (b2b) begin
								c_tx     <= hold_word;
								c_mosi   <= hold_word[WORD_BITS-1];
								edge_cnt <= '0;
								tmr      <= half_lo;
							end else begin
								tmr <= lag_cyc;
								cst <= C_LAG;
							end
						end
					end
				end
				C_LAG: begin
					if (tmr == TMR_ONE) begin
						c_cs_n <= 1'b1;
						cst    <= C_IDLE;
					end else begin
						tmr <= tmr - TMR_ONE;
					end
				end
				default: begin
					cst    <= C_IDLE;
					c_cs_n <= RST_CS_N;
				end
				endcase
			end
		end
	end

	// peripheral engine
	logic                 sclk_prev;
	logic                 p_rise;
	logic                 p_fall;
	logic                 p_upd;
	logic                 p_smp;
	logic                 p_active;
	logic [WORD_BITS-1:0] p_tx;
	logic [WORD_BITS-1:0] p_rx;
	logic [CNT_BITS-1:0]  p_cnt;
	logic                 p_sampled;
	logic                 p_miso;
	logic                 p_done;
	logic [WORD_BITS-1:0] p_word;

	always_comb begin
		p_active = !controller_sel && !cs_n_s;
		p_rise   = p_active && sclk_s && !sclk_prev;
		p_fall   = p_active && !sclk_s && sclk_prev;
		p_upd    = (pol == pha) ? p_rise : p_fall;
		p_smp    = (pol == pha) ? p_fall : p_rise;
	end

	// host opens a fresh select per word, so no reload mid-select
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sclk_prev <= RST_SCLK;
			cs_n_prev <= RST_CS_N;
			p_tx      <= '0;
			p_rx      <= '0;
			p_cnt     <= '0;
			p_sampled <= 1'b0;
			p_miso    <= RST_DATA;
			p_done    <= 1'b0;
			p_word    <= '0;
		end else begin
			sclk_prev <= sclk_s;
			cs_n_prev <= cs_n_s;
			p_done    <= 1'b0;
			if (p_cs_fall) begin
				p_tx      <= p_take ? hold_word : '0;
				p_miso    <= p_take ? hold_word[WORD_BITS-1] : 1'b0;
				p_cnt     <= '0;
				p_sampled <= 1'b0;
			end else begin
				if (p_smp) begin
					p_rx      <= {p_rx[WORD_BITS-2:0], mosi_s};
					p_sampled <= 1'b1;
					p_cnt     <= (p_cnt == LAST_BIT) ? '0 : p_cnt + 1'b1;
					if (p_cnt == LAST_BIT) begin
						p_done <= 1'b1;
						p_word <= {p_rx[WORD_BITS-2:0], mosi_s};
					end
				end
				// first update edge before any sample keeps the top bit out
				if (p_upd && p_sampled) begin
					p_tx      <= {p_tx[WORD_BITS-2:0], 1'b0};
					p_miso    <= p_tx[WORD_BITS-2];
					p_sampled <= 1'b0;
				end
			end
		end
	end

	// pin steering, received words and status
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			serial_clk_o       <= RST_SCLK;
			serial_clk_oe_n    <= 1'b1;
			cs_n_o             <= RST_CS_N;
			cs_oe_n            <= 1'b1;
			ctrl_out_data_o    <= RST_DATA;
			ctrl_out_data_oe_n <= 1'b1;
			ctrl_in_data_o     <= RST_DATA;
			ctrl_in_data_oe_n  <= 1'b1;
			rx_word            <= '0;
			rx_valid           <= 1'b0;
			busy               <= 1'b0;
			sclk_rate_fault    <= 1'b0;
		end else begin
			serial_clk_o       <= sclk;
			serial_clk_oe_n    <= !controller_sel;
			cs_n_o             <= c_cs_n;
			cs_oe_n            <= !controller_sel;
			ctrl_out_data_o    <= c_mosi;
			ctrl_out_data_oe_n <= !controller_sel;
			ctrl_in_data_o     <= p_miso;
			ctrl_in_data_oe_n  <= !p_active;
			rx_valid           <= c_done || p_done;
			if (c_done) begin
				rx_word <= c_word;
			end else if (p_done) begin
				rx_word <= p_word;
			end
			busy <= controller_sel ? (cst != C_IDLE) : p_active;
			// flags settings the far side promised to avoid
			sclk_rate_fault <= period < TMR_BITS'(MIN_PERIOD_CYC);
		end
	end
endmodule

// ===== rtl/scp_sync.sv
// three-stage input synchroniser, one lane per bit.
// output changes only once the second and third stages agree.
`timescale 1ns/1ps
module scp_sync #(
	parameter int               WIDTH     = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input  wire logic             clk,
	input  wire logic             resetn,
	// lanes
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] stable
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_lane
			always_ff @(posedge clk or negedge resetn) begin
				if (!resetn) begin
					s1[i]     <= RESET_VAL[i];
					s2[i]     <= RESET_VAL[i];
					s3[i]     <= RESET_VAL[i];
					stable[i] <= RESET_VAL[i];
				end else begin
					s1[i] <= async_in[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						stable[i] <= s3[i];
					end
				end
			end
		end
	endgenerate
endmodule

// ===== test/scp_far_end.sv
// far-end spi peripheral facing the port in controller mode.
// assumes the bench resolves the shared pins before they reach it.
`timescale 1ns/1ps
module scp_far_end (
	// link pins
	input  wire logic        sclk,
	input  wire logic        cs_n,
	input  wire logic        mosi,
	output logic             miso,
	// setup and result
	input  wire logic        pol,
	input  wire logic        pha,
	input  wire logic [15:0] reply,
	output logic      [15:0] got
);
	logic [15:0] sh;
	logic        mosi_d;
	// line as seen just before an edge that may move it too
	// start at the pin's reset level so a quiet line never reads unknown
	initial mosi_d = 1'b0;
	always @(mosi) mosi_d <= #1 mosi;
	initial miso = 1'b0;
	always @(negedge cs_n) begin
		sh   = reply;
		got  = 16'h0000;
		miso = sh[15];
	end
	// released line shows the inverse of its last bit
	always @(posedge cs_n) miso = ~miso;
	always @(sclk) if (!cs_n) begin
		if ((sclk != pol) ^ pha) got = {got[14:0], mosi_d};
		else if (pha) begin
			miso = sh[15];
			sh   = sh << 1;
		end else begin
			sh   = sh << 1;
			miso = sh[15];
		end
	end
endmodule

// ===== test/scp_spi_properties.sv
// checker: pin timing relations of the dual-role spi port.
// assumes configuration ports stay steady while a word is on the wire.
`timescale 1ns/1ps
module scp_spi_properties
	import scp_pkg::*;
(
	// clock and reset
	input wire logic        clk,
	input wire logic        resetn,
	// configuration
	input wire logic        controller_sel,
	input wire scp_format_s format_reg,
	input wire scp_delay_s  cs_delay_reg,
	input wire logic        cs_keep_asserted,
	// status and pins
	input wire logic        rx_valid,
	input wire logic        serial_clk_o,
	input wire logic        serial_clk_oe_n,
	input wire logic        cs_n_i,
	input wire logic        cs_n_o,
	input wire logic        cs_oe_n,
	input wire logic        ctrl_out_data_oe_n,
	input wire logic        ctrl_in_data_oe_n
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	logic       sc_q;
	logic       cs_q;
	logic [9:0] gap;
	logic [7:0] ec;
	wire        edg = serial_clk_o != sc_q;
	wire  [9:0] per = format_reg.clk_prescale == 8'h00 ? 10'h002 :
		{2'h0, format_reg.clk_prescale} + 10'h001;
	wire  [9:0] lo  = per >> 1;
	// gap: cycles since last clock edge or select fall
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sc_q <= RST_SCLK;
			cs_q <= RST_CS_N;
			gap  <= 10'h000;
			ec   <= 8'h00;
		end else begin
			sc_q <= serial_clk_o;
			cs_q <= cs_n_o;
			gap  <= (edg || (cs_q && !cs_n_o)) ? 10'h001 : gap + 10'h001;
			ec   <= cs_n_o ? 8'h00 : ec + {7'h00, edg};
		end
	end
	a_ctrl_drives_pins: assert property (
		controller_sel && $past(controller_sel) && $past(resetn)
		|-> !serial_clk_oe_n && !cs_oe_n && !ctrl_out_data_oe_n)
		else $error("controller pins not driven");
	a_peri_releases: assert property (
		!controller_sel && !$past(controller_sel) && $past(resetn)
		|-> serial_clk_oe_n && cs_oe_n && ctrl_out_data_oe_n)
		else $error("peripheral drives controller pins");
	a_half_period: assert property (
		controller_sel && edg && !cs_n_o && ec[4:0] != 5'h00
		|-> gap == lo || gap == per - lo)
		else $error("serial clock half period wrong");
	a_lead_wait: assert property (
		controller_sel && format_reg.phase && edg && !cs_n_o && ec == 8'h00
		|-> gap == lo + {2'h0, cs_delay_reg.cs_lead_delay} + 10'h002 +
		{9'h000, cs_keep_asserted & format_reg.polarity})
		else $error("lead wait wrong");
	a_lag_release: assert property (
		controller_sel && $past(controller_sel) && $rose(cs_n_o) &&
		format_reg.phase |-> ec[4:0] == 5'h00 && ec != 8'h00 &&
		gap == {2'h0, cs_delay_reg.cs_lag_delay} + 10'h001)
		else $error("lag wait wrong");
	a_idle_level: assert property (
		controller_sel && $past(controller_sel, 2) && $past(resetn, 2) &&
		cs_n_o && $past(cs_n_o) && $stable(format_reg.polarity) &&
		format_reg.polarity == $past(format_reg.polarity, 2)
		|-> serial_clk_o == format_reg.polarity)
		else $error("idle clock level wrong");
	a_rx_after_last: assert property (
		controller_sel && edg && !cs_n_o && ec[4:0] == 5'h1F
		|-> rx_valid)
		else $error("no word after last edge");
	a_reply_drive: assert property (
		(!controller_sel && !cs_n_i) [*6] |-> !ctrl_in_data_oe_n)
		else $error("reply pin not driven");
	c_ctrl_word: cover property (controller_sel && rx_valid);
	c_peri_word: cover property (!controller_sel && rx_valid);
	c_hold_chain: cover property (edg && ec == 8'h20);
endmodule

bind scp_spi scp_spi_properties u_props (.clk, .resetn, .controller_sel,
	.format_reg, .cs_delay_reg, .cs_keep_asserted, .rx_valid, .serial_clk_o,
	.serial_clk_oe_n, .cs_n_i, .cs_n_o, .cs_oe_n, .ctrl_out_data_oe_n,
	.ctrl_in_data_oe_n);

// ===== test/scp_spi_tb_top.sv
// bench: controller words in all modes, held select, peripheral words.
// assumes the far-end model and the checker are compiled beforehand.
`timescale 1ns/1ps
module scp_spi_tb_top
	import scp_pkg::*;
;
	`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin \
		miscompares++; $display("[FAIL] %0t mismatch", $time); end end
	logic        clk, resetn, controller_sel, cs_keep_asserted, tx_valid;
	scp_format_s format_reg;
	scp_delay_s  cs_delay_reg;
	logic [15:0] tx_word, rx_word, reply, got, hw, tw, r;
	logic        tx_ready, rx_valid, busy, sclk_rate_fault, p_miso;
	logic        serial_clk_o, serial_clk_oe_n, cs_n_o, cs_oe_n;
	logic        ctrl_out_data_o, ctrl_out_data_oe_n;
	logic        ctrl_in_data_o, ctrl_in_data_oe_n, h_sclk, h_cs, h_mosi;
	int          miscompares, samples_checked, cyc, rises, n;
	logic [15:0] exp_q[$];
	wire         serial_clk_i = serial_clk_oe_n ? h_sclk : serial_clk_o;
	wire         cs_n_i = cs_oe_n ? h_cs : cs_n_o;
	wire         ctrl_out_data_i = ctrl_out_data_oe_n ? h_mosi :
		ctrl_out_data_o;
	wire         ctrl_in_data_i = ctrl_in_data_oe_n ? p_miso : ctrl_in_data_o;
	scp_spi dut (.clk, .resetn, .controller_sel, .format_reg, .cs_delay_reg,
		.cs_keep_asserted, .tx_word, .tx_valid, .tx_ready, .rx_word,
		.rx_valid, .busy, .sclk_rate_fault, .serial_clk_i, .serial_clk_o,
		.serial_clk_oe_n, .cs_n_i, .cs_n_o, .cs_oe_n, .ctrl_out_data_i,
		.ctrl_out_data_o, .ctrl_out_data_oe_n, .ctrl_in_data_i,
		.ctrl_in_data_o, .ctrl_in_data_oe_n);
	scp_far_end u_far (.sclk(serial_clk_i), .cs_n(cs_n_i),
		.mosi(ctrl_out_data_i), .miso(p_miso), .pol(format_reg.polarity),
		.pha(format_reg.phase), .reply, .got);
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge cs_n_o) rises++;
	// reference model: received words in order of expectation
	always @(posedge clk) begin
		cyc++;
		if (rx_valid === 1'b1) `CHK(rx_word, exp_q.pop_front())
		if (cyc == 20000) begin
			miscompares++;
			$display("[FAIL] %0t timeout", $time);
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	task automatic send(input logic [15:0] w);
		for (int k = 0; k < 400 && tx_ready !== 1'b1; k++) tick(1);
		tx_word  = w;
		tx_valid = 1'b1;
		tick(1);
		tx_valid = 1'b0;
	endtask
	task automatic idle();
		tick(4);
		for (int k = 0; k < 3000 && busy !== 1'b0; k++) tick(1);
		tick(3);
	endtask
	// host in the far side's place when the port is a peripheral
	task automatic host(input logic [15:0] w);
		int i;
		i = 0;
		r = 16'h0000;
		h_mosi = w[15];
		h_cs = 1'b0;
		tick(32); // two clock periods before the first edge
		repeat (32) begin
			h_sclk = ~h_sclk;
			if (h_sclk != (format_reg.polarity == format_reg.phase)) begin
				r = {r[14:0], ctrl_in_data_i};
				i++;
			end else if (i > 0 && i < 16) h_mosi = w[15 - i];
			tick(8);
		end
		h_cs = 1'b1; // one select toggle per word
		h_mosi = ~h_mosi;
		idle();
	endtask
	initial begin
		{resetn, cs_keep_asserted, tx_valid, h_sclk, h_mosi} = 5'h00;
		{controller_sel, h_cs} = 2'h3;
		{format_reg, cs_delay_reg, tx_word, reply} = '0;
		{miscompares, samples_checked, cyc, rises} = '0;
		void'($urandom(78610));
		repeat (20) @(posedge clk);
		`CHK({tx_ready, cs_oe_n, cs_n_o}, 3'b011)
		#1 resetn = 1'b1;
		for (int p = 0; p < 3; p++) begin
			format_reg.clk_prescale = 8'(p);
			tick(3);
			`CHK(sclk_rate_fault, p < 2)
		end
		for (int m = 0; m < 4; m++) begin
			// prescale kept at 15 or more: period well above 25 ns
			format_reg = '{m[1], m[0], 8'h0F + 8'(m)};
			cs_delay_reg = '{8'($urandom_range(3)), 8'($urandom_range(3))};
			tick(2);
			reply = 16'($urandom);
			exp_q.push_back(reply);
			tw = 16'($urandom);
			send(tw);
			tick(3);
			`CHK(busy, 1'b1)
			idle();
			`CHK(got, tw)
		end
		cs_keep_asserted = 1'b1;
		format_reg = '{1'b1, 1'b1, 8'h10};
		tick(2);
		n = rises;
		reply = 16'($urandom);
		exp_q.push_back(reply);
		exp_q.push_back(16'h0000);
		hw = 16'($urandom);
		send(16'($urandom));
		send(hw);
		idle();
		`CHK(got, hw)
		`CHK(rises - n, 1)
		{cs_keep_asserted, controller_sel} = 2'h0;
		for (int m = 0; m < 4; m++) begin
			format_reg = '{m[1], m[0], 8'h02};
			h_sclk = m[1];
			tick(4);
			hw = 16'($urandom);
			tw = 16'($urandom);
			exp_q.push_back(hw);
			send(tw);
			host(hw);
			`CHK(r, tw)
		end
		`CHK(exp_q.size(), 0)
		end_sim();
	end
endmodule
